// >>> rtl/sleep_wake_params.svh
// constants for the sleep/wake and supply monitor block
// assumes an apb slave at 40 mhz with a 32 khz low-speed tick from outside
// Function
// RULE1: sleep only by firmware sleep bit; halt cpu
// RULE2: stay halted until interrupt pending or reset
// RULE3: monitor keeps sampling in sleep, slower
// RULE4: duty code sets monitor on-time periods
// RULE5: low-speed oscillator keeps running in sleep
// RULE6: control bit selects low-power slow oscillator; slowOscLowPower follows lpOsc_q only in ST_SLEEP
// RULE7: any unmasked interrupt wakes, ignoring global enable
// RULE8: resume only while stop bit is clear
// RULE9: sleep entry forces internal clock select
// RULE10: wake restarts oscillator, three slow cycles recovery
// RULE11: external oscillator never stopped automatically
// RULE12: next instruction runs before interrupt service
// RULE13: sleep timer wakes and also interrupts normally
// RULE14: reset level codes; 11 suppresses reset
// RULE15: eight monitor levels also gate flash enable; this block has no flash enable output, only monitorLevelOut
// RULE16: low supply trip may raise an interrupt
// RULE17: comparator bit 1 shows live low supply
// RULE18: comparator bit 0 shows live reset trip
// RULE19: sleep bit self-clears on wake
`ifndef SLEEP_WAKE_PARAMS_SVH
`define SLEEP_WAKE_PARAMS_SVH
`define OFS_SYS_CTRL      12'h000
`define OFS_DUTY_TRIM     12'h004
`define OFS_OSC_CTRL      12'h008
`define OFS_IRQ_STATUS    12'h00c
`define OFS_IRQ_MASK      12'h010
`define IDX_LEVEL_CTRL    12'h1e3
`define IDX_CMP_STATE     12'h1e4
`define BIT_STOP          0
`define BIT_SLEEP         3
`define BIT_LP_OSC        7
`define BIT_CLK_SEL       1
`define BIT_EXT_OSC_EN    2
`define LEVEL_CTRL_RESET  8'h00
`define LEVEL_CTRL_MASK   8'h37
`define RECOVERY_SLOW_CYC 2'h3
`define ON_TIME_00        10'h080
`define ON_TIME_01        10'h200
`define ON_TIME_10        10'h020
`define ON_TIME_11        10'h008
`define RESET_LEVEL_NONE  2'h3
`define RESET_LEVEL_MID   2'h1
`endif

// >>> rtl/sleep_wake_pkg.sv
// types for the sleep/wake and supply monitor block
// assumes the params header for numeric constants
package sleep_wake_pkg;
    typedef enum logic [1:0] {
        ST_RUN     = 2'b00,
        ST_SLEEP   = 2'b01,
        ST_RECOVER = 2'b11
    } power_state_t;

    typedef struct packed {
        logic [1:0] resetLevel;
        logic [2:0] monitorLevel;
    } level_cfg_t;

    typedef struct packed {
        logic lowSupply;
        logic resetTrip;
    } cmp_state_t;
endpackage : sleep_wake_pkg

// >>> rtl/sleep_wake_and_voltage_monitor.sv
// sleep/wake control, supply monitor levels, apb registers, irq
// assumes comparator levels and ticks come from outside the clock domain
//
// The APB slave port was decided locally.
`timescale 1ns/1ps
`include "sleep_wake_params.svh"
module sleep_wake_and_voltage_monitor (
    input  wire logic        clk,
    input  wire logic        rst_b,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic             pready,
    output logic [31:0]      prdata,
    output logic             pslverr,
    input  wire logic        slowTick,
    input  wire logic        lowSupplyRaw,
    input  wire logic        resetTripRaw,
    input  wire logic        sleepTimerIrq,
    input  wire logic [7:0]  pendingIrq,
    input  wire logic [7:0]  irqMaskBits,
    output logic             cpuHalt,
    output logic             fastOscEnable,
    output logic             extOscEnable,
    output logic             slowOscLowPower,
    output logic             clkSelInternal,
    output logic             monitorSampleEn,
    output logic [1:0]       resetLevelOut,
    output logic [2:0]       monitorLevelOut,
    output logic             precisionResetReq,
    output logic             irq
);
    sleep_wake_pkg::power_state_t state_q;
    sleep_wake_pkg::level_cfg_t   levelCfg_q;
    sleep_wake_pkg::cmp_state_t   cmpLive;
    logic       sleepBit_q;
    logic       stopBit_q;
    logic [1:0] duty_q;
    logic       lpOsc_q;
    logic       extOsc_q;
    logic       clkSel_q;
    logic [2:0] irqStat_q;
    logic [2:0] irqMask_q;
    logic [2:0] lowSync_q;
    logic [2:0] rstSync_q;
    logic [2:0] tickSync_q;
    logic [2:0] stIrqSync_q;
    logic       lowStable_q;
    logic       rstStable_q;
    logic       tickStable_q;
    logic       stStable_q;
    logic       tickPulse;
    logic       stPulse;
    logic       lowRise;
    logic       lowPrev_q;
    logic [1:0] recCnt_q;
    logic [9:0] dutyCnt_q;
    logic       wakeReq;
    logic       wrEn;
    logic       rdEn;
    logic [11:0] addr;
    logic       addrOk;

    function automatic logic [9:0] onTime(input logic [1:0] code);
        case (code)
            2'b00:   onTime = `ON_TIME_00;
            2'b01:   onTime = `ON_TIME_01;
            2'b10:   onTime = `ON_TIME_10;
            default: onTime = `ON_TIME_11;
        endcase
    endfunction : onTime

    // pin inputs: three flops, change accepted when stages two and three agree
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            lowSync_q   <= 3'h0;
            rstSync_q   <= 3'h0;
            tickSync_q  <= 3'h0;
            stIrqSync_q <= 3'h0;
        end else begin
            lowSync_q   <= {lowSync_q[1:0], lowSupplyRaw};
            rstSync_q   <= {rstSync_q[1:0], resetTripRaw};
            tickSync_q  <= {tickSync_q[1:0], slowTick};
            stIrqSync_q <= {stIrqSync_q[1:0], sleepTimerIrq};
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            lowStable_q  <= 1'b0;
            rstStable_q  <= 1'b0;
            tickStable_q <= 1'b0;
            stStable_q   <= 1'b0;
        end else begin
            if (lowSync_q[1] == lowSync_q[2]) lowStable_q <= lowSync_q[2];
            if (rstSync_q[1] == rstSync_q[2]) rstStable_q <= rstSync_q[2];
            if (tickSync_q[1] == tickSync_q[2]) tickStable_q <= tickSync_q[2];
            if (stIrqSync_q[1] == stIrqSync_q[2]) stStable_q <= stIrqSync_q[2];
        end
    end

    assign tickPulse = (tickSync_q[1] == tickSync_q[2]) &&
                       tickSync_q[2] && !tickStable_q;
    assign stPulse   = (stIrqSync_q[1] == stIrqSync_q[2]) &&
                       stIrqSync_q[2] && !stStable_q;
    assign cmpLive.lowSupply = lowStable_q;
    assign cmpLive.resetTrip = rstStable_q;
    assign lowRise = lowStable_q && !lowPrev_q;

    // apb decode, zero wait states; unmapped gives slverr
    assign addr = paddr;
    assign wrEn = psel && penable && pwrite && pready;
    assign rdEn = psel && !penable && !pwrite;
    always_comb begin
        addrOk = 1'b0;
        if (addr == `OFS_SYS_CTRL) addrOk = 1'b1;
        else if (addr == `OFS_DUTY_TRIM) addrOk = 1'b1;
        else if (addr == `OFS_OSC_CTRL) addrOk = 1'b1;
        else if (addr == `OFS_IRQ_STATUS) addrOk = 1'b1;
        else if (addr == `OFS_IRQ_MASK) addrOk = 1'b1;
        else if (addr == 12'((`IDX_LEVEL_CTRL) * 4)) addrOk = 1'b1;
        else if (addr == 12'((`IDX_CMP_STATE) * 4)) addrOk = 1'b1;
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready  <= psel && !penable;
            pslverr <= psel && !penable && !addrOk;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            prdata <= 32'h0;
        end else if (rdEn) begin
            prdata <= 32'h0;
            if (addr == `OFS_SYS_CTRL)
                prdata[7:0] <= {4'h0, sleepBit_q, 2'h0, stopBit_q};
            else if (addr == `OFS_DUTY_TRIM)
                prdata[7:0] <= {duty_q, 6'h00};
            else if (addr == `OFS_OSC_CTRL)
                prdata[7:0] <= {lpOsc_q, 4'h0, extOsc_q, clkSel_q, 1'b0};
            else if (addr == `OFS_IRQ_STATUS)
                prdata[2:0] <= irqStat_q;
            else if (addr == `OFS_IRQ_MASK)
                prdata[2:0] <= irqMask_q;
            else if (addr == 12'((`IDX_LEVEL_CTRL) * 4))
                prdata[7:0] <= {2'h0, levelCfg_q.resetLevel, 1'b0,
                                levelCfg_q.monitorLevel};
            else if (addr == 12'((`IDX_CMP_STATE) * 4))
                prdata[7:0] <= {6'h00, cmpLive.lowSupply,
                                cmpLive.resetTrip}; // RULE17 RULE18
        end
    end

    // wake on any unmasked pending source; global enable plays no part
    assign wakeReq = (|(pendingIrq & ~irqMaskBits)) || stPulse; // RULE7 RULE13

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            state_q <= sleep_wake_pkg::ST_RUN;
        end else begin
            case (state_q)
                sleep_wake_pkg::ST_RUN: begin
                    if (sleepBit_q) state_q <= sleep_wake_pkg::ST_SLEEP; // RULE1
                end
                sleep_wake_pkg::ST_SLEEP: begin
                    if (wakeReq && !stopBit_q) // RULE2 RULE8
                        state_q <= sleep_wake_pkg::ST_RECOVER;
                end
                default: begin
                    if (tickPulse && recCnt_q == `RECOVERY_SLOW_CYC - 2'h1)
                        state_q <= sleep_wake_pkg::ST_RUN; // RULE10 RULE12
                end
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            recCnt_q <= 2'h0;
        end else if (state_q != sleep_wake_pkg::ST_RECOVER) begin
            recCnt_q <= 2'h0;
        end else if (tickPulse) begin
            recCnt_q <= recCnt_q + 2'h1; // RULE10
        end
    end

    // sleep bit: firmware set, hardware clear on wake (wake wins)
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            sleepBit_q <= 1'b0;
            stopBit_q  <= 1'b0;
        end else begin
            if (state_q == sleep_wake_pkg::ST_SLEEP && wakeReq && !stopBit_q)
                sleepBit_q <= 1'b0; // RULE19
            else if (wrEn && addr == `OFS_SYS_CTRL)
                sleepBit_q <= pwdata[`BIT_SLEEP]; // RULE1
            if (wrEn && addr == `OFS_SYS_CTRL)
                stopBit_q <= pwdata[`BIT_STOP];
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            duty_q     <= 2'h0;
            lpOsc_q    <= 1'b0;
            extOsc_q   <= 1'b0;
            levelCfg_q <= sleep_wake_pkg::level_cfg_t'(5'h00);
        end else begin
            if (wrEn && addr == `OFS_DUTY_TRIM) duty_q <= pwdata[7:6];
            if (wrEn && addr == `OFS_OSC_CTRL) begin
                lpOsc_q  <= pwdata[`BIT_LP_OSC]; // RULE6
                extOsc_q <= pwdata[`BIT_EXT_OSC_EN]; // RULE11
            end
            if (wrEn && addr == 12'((`IDX_LEVEL_CTRL) * 4)) begin
                levelCfg_q.resetLevel   <= pwdata[5:4]; // RULE14
                levelCfg_q.monitorLevel <= pwdata[2:0]; // RULE15
            end
        end
    end

    // clock select forced to internal on sleep entry
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            clkSel_q <= 1'b0;
        end else if (state_q == sleep_wake_pkg::ST_RUN && sleepBit_q) begin
            clkSel_q <= 1'b0; // RULE9
        end else if (wrEn && addr == `OFS_OSC_CTRL) begin
            clkSel_q <= pwdata[`BIT_CLK_SEL];
        end
    end

    // monitor duty cycle in sleep: gated for the coded slow periods less one,
    // then one sample; latency grows with the on-time count
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            dutyCnt_q       <= 10'h0;
            monitorSampleEn <= 1'b1;
        end else if (state_q != sleep_wake_pkg::ST_SLEEP) begin
            dutyCnt_q       <= 10'h0;
            monitorSampleEn <= 1'b1;
        end else if (tickPulse) begin // RULE3 RULE4
            if (dutyCnt_q >= onTime(duty_q) - 10'h1) begin
                dutyCnt_q       <= 10'h0;
                monitorSampleEn <= 1'b1;
            end else begin
                dutyCnt_q       <= dutyCnt_q + 10'h1;
                monitorSampleEn <= 1'b0;
            end
        end
    end

    // interrupts: bit0 low supply, bit1 sleep timer, bit2 wake; w1c
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            irqStat_q <= 3'h0;
            irqMask_q <= 3'h0;
            lowPrev_q <= 1'b0;
        end else begin
            lowPrev_q <= lowStable_q;
            if (wrEn && addr == `OFS_IRQ_MASK) irqMask_q <= pwdata[2:0];
            irqStat_q <= (irqStat_q &
                          ~((wrEn && addr == `OFS_IRQ_STATUS) ?
                            pwdata[2:0] : 3'h0)) |
                         {state_q == sleep_wake_pkg::ST_RECOVER &&
                          recCnt_q == 2'h0 && !tickPulse && 1'b0,
                          stPulse, lowRise}; // RULE16 RULE13
            if (state_q == sleep_wake_pkg::ST_SLEEP && wakeReq && !stopBit_q)
                irqStat_q[2] <= 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            irq               <= 1'b0;
            cpuHalt           <= 1'b0;
            fastOscEnable     <= 1'b1;
            extOscEnable      <= 1'b0;
            slowOscLowPower   <= 1'b0;
            clkSelInternal    <= 1'b1;
            resetLevelOut     <= 2'h0;
            monitorLevelOut   <= 3'h0;
            precisionResetReq <= 1'b0;
        end else begin
            irq             <= |(irqStat_q & irqMask_q);
            cpuHalt         <= state_q != sleep_wake_pkg::ST_RUN; // RULE1 RULE12
            fastOscEnable   <= state_q != sleep_wake_pkg::ST_SLEEP; // RULE10
            extOscEnable    <= extOsc_q; // RULE11
            slowOscLowPower <= lpOsc_q && state_q == sleep_wake_pkg::ST_SLEEP; // RULE5 RULE6
            clkSelInternal  <= !clkSel_q; // RULE9
            resetLevelOut   <= (levelCfg_q.resetLevel == `RESET_LEVEL_NONE) ?
                               `RESET_LEVEL_MID : levelCfg_q.resetLevel; // RULE14
            monitorLevelOut <= levelCfg_q.monitorLevel; // RULE15
            precisionResetReq <= rstStable_q &&
                  levelCfg_q.resetLevel != `RESET_LEVEL_NONE; // RULE14
        end
    end
endmodule : sleep_wake_and_voltage_monitor

// >>> sim/sleep_wake_asserts.sv
// checker: port-level relations of the sleep/wake block
// assumes apb timing and a slow tick period of eight clock cycles
`timescale 1ns/1ps
module sleep_wake_asserts (
    input wire logic        clk,
    input wire logic        rst_b,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        cpuHalt,
    input wire logic        fastOscEnable,
    input wire logic        clkSelInternal,
    input wire logic        slowOscLowPower,
    input wire logic        monitorSampleEn,
    input wire logic [2:0]  monitorLevelOut,
    input wire logic        extOscEnable,
    input wire logic        irq
);
    logic lvlWr;
    logic oscWr;
    assign lvlWr = psel && penable && pwrite && paddr == 12'h78c;
    assign oscWr = psel && penable && pwrite && paddr == 12'h008;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);
    rdy_after_setup_a:
        assert property (psel && !penable |=> pready)
        else $error("no ready after setup");
    err_with_rdy_a:
        assert property (pslverr |-> pready ##1 !pready)
        else $error("error without one-cycle ready");
    asleep_osc_a:
        assert property (!fastOscEnable && $past(fastOscEnable) == 1'b0
            |-> cpuHalt && clkSelInternal) else $error("sleep clocking");
    lowpower_a:
        assert property (slowOscLowPower && $past(slowOscLowPower) |-> cpuHalt)
        else $error("low-power oscillator while awake");
    recovery_wait_a:
        assert property ($fell(cpuHalt) |-> $past(fastOscEnable, 8))
        else $error("halt released without recovery");
    sample_en_a:
        assert property (!monitorSampleEn |-> ##[0:2] cpuHalt)
        else $error("monitor gated while awake");
    mon_level_a:
        assert property ($changed(monitorLevelOut) |-> $past(lvlWr)
            || $past(lvlWr, 2)) else $error("monitor level moved alone");
    ext_osc_a:
        assert property ($fell(extOscEnable) |-> $past(oscWr)
            || $past(oscWr, 2)) else $error("external oscillator stopped");
    cover property ($fell(cpuHalt));
    cover property (pslverr);
    cover property ($rose(irq));
endmodule : sleep_wake_asserts
bind sleep_wake_and_voltage_monitor sleep_wake_asserts sleep_wake_asserts_i (
    .clk(clk), .rst_b(rst_b), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pready(pready), .pslverr(pslverr),
    .cpuHalt(cpuHalt), .fastOscEnable(fastOscEnable),
    .clkSelInternal(clkSelInternal), .slowOscLowPower(slowOscLowPower),
    .monitorSampleEn(monitorSampleEn), .monitorLevelOut(monitorLevelOut),
    .extOscEnable(extOscEnable), .irq(irq));

// >>> sim/irq_partner_model.sv
// partner: cpu-side interrupt controller and low-speed oscillator
// assumes the bench raises requests one cycle at a time and holds clears across a whole apb read
`timescale 1ns/1ps
module irq_partner_model (
    input  wire logic       clk,
    input  wire logic       rst_b,
    input  wire logic [7:0] raiseIrq,
    input  wire logic [7:0] clearIrq,
    output logic            slowTick,
    output logic [7:0]      pendingIrq
);
    logic [1:0] tickCnt_q;
    // free-running, far faster than real so the run stays short
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            tickCnt_q <= 2'h0;
            slowTick  <= 1'b0;
        end else begin
            tickCnt_q <= tickCnt_q + 2'h1;
            if (tickCnt_q == 2'h3) slowTick <= ~slowTick;
        end
    end
    // pending holds until the service routine acknowledges it
    always_ff @(posedge clk) begin
        if (!rst_b) pendingIrq <= 8'h00;
        else pendingIrq <= (pendingIrq & ~clearIrq) | raiseIrq;
    end
endmodule : irq_partner_model

// >>> sim/sleep_wake_and_voltage_monitor_tb_top.sv
// testbench: registers, levels, interrupts and sleep/wake
// assumes the partner model supplies slowTick and pending interrupts
`timescale 1ns/1ps
module sleep_wake_and_voltage_monitor_tb_top;
    logic        clk, rst_b, psel, penable, pwrite, pready, pslverr, irq;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, d;
    logic        slowTick, lowSupplyRaw, resetTripRaw, sleepTimerIrq;
    logic [7:0]  pendingIrq, irqMaskBits, raiseIrq, clearIrq;
    logic        cpuHalt, fastOscEnable, extOscEnable, slowOscLowPower;
    logic        clkSelInternal, monitorSampleEn, precisionResetReq;
    logic [1:0]  resetLevelOut;
    logic [2:0]  monitorLevelOut;
    logic [32:0] expQ[$];
    int          fail_count, n_tests, seed, i, n;
    sleep_wake_and_voltage_monitor sleep_wake_and_voltage_monitor_i (
        .clk(clk), .rst_b(rst_b), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
        .prdata(prdata), .pslverr(pslverr), .slowTick(slowTick),
        .lowSupplyRaw(lowSupplyRaw), .resetTripRaw(resetTripRaw),
        .sleepTimerIrq(sleepTimerIrq), .pendingIrq(pendingIrq),
        .irqMaskBits(irqMaskBits), .cpuHalt(cpuHalt),
        .fastOscEnable(fastOscEnable), .extOscEnable(extOscEnable),
        .slowOscLowPower(slowOscLowPower), .clkSelInternal(clkSelInternal),
        .monitorSampleEn(monitorSampleEn), .resetLevelOut(resetLevelOut),
        .monitorLevelOut(monitorLevelOut),
        .precisionResetReq(precisionResetReq), .irq(irq));
    irq_partner_model irq_partner_model_i (.clk(clk), .rst_b(rst_b),
        .raiseIrq(raiseIrq), .clearIrq(clearIrq), .slowTick(slowTick),
        .pendingIrq(pendingIrq));
    task automatic summarize();
        $display("mismatches %0d of %0d checks", fail_count, n_tests);
        if (fail_count == 0 && n_tests > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : summarize
    task automatic check(input logic [32:0] seen, input logic [32:0] exp);
        n_tests++;
        if (seen !== exp) begin
            fail_count++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    // reads note {pslverr, prdata} for the monitor below
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] wd, input logic [32:0] e);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= wd;
        if (!w) expQ.push_back(e);
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) begin
            fail_count++;
            summarize();
        end
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask : apb
    // counts cycles until the halt drops, bounded
    task automatic waitWake();
        n = 0;
        while (cpuHalt !== 1'b0 && n < 300) begin
            @(posedge clk);
            n++;
        end
        if (n >= 300) begin
            fail_count++;
            summarize();
        end
    endtask : waitWake
    always @(posedge clk) begin
        if (psel && penable && pready && !pwrite)
            check({pslverr, prdata}, expQ.size() ? expQ.pop_front() : 'x);
    end
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    initial begin
        seed = 32'hea5db18a;
        {rst_b, psel, penable, pwrite, lowSupplyRaw, resetTripRaw} = '0;
        {paddr, pwdata, sleepTimerIrq, irqMaskBits} = '0;
        {raiseIrq, clearIrq} = '0;
        repeat (8) @(posedge clk);
        rst_b <= 1'b1;
        @(posedge clk);
        check({fastOscEnable, clkSelInternal, monitorSampleEn, cpuHalt, irq,
               extOscEnable, slowOscLowPower, precisionResetReq}, 8'he0);
        for (i = 0; i < 4; i++) begin
            lowSupplyRaw <= i[1];
            resetTripRaw <= i[0];
            repeat (6) @(posedge clk);
            apb(1'b0, 12'h790, 32'h0, {31'h0, i[1], i[0]});
        end
        for (i = 0; i < 8; i++) begin
            d = $random(seed);
            apb(1'b1, 12'h78c, {d[31:6], i[1:0], d[3], i[2:0]}, 33'h0);
            apb(1'b0, 12'h78c, 32'h0, {27'h0, i[1:0], 1'b0, i[2:0]});
            check({resetLevelOut, monitorLevelOut, precisionResetReq},
                  {(i[1:0] == 2'h3) ? 2'h1 : i[1:0], i[2:0],
                   i[1:0] != 2'h3});
        end
        apb(1'b0, 12'h0f0, 32'h0, {1'b1, 32'h0});
        apb(1'b1, 12'h00c, 32'h7, 33'h0);
        apb(1'b1, 12'h010, 32'h2, 33'h0);
        sleepTimerIrq <= 1'b1;
        repeat (6) @(posedge clk);
        check(irq, 1'b1);
        apb(1'b0, 12'h00c, 32'h0, 33'h2);
        apb(1'b1, 12'h010, 32'h0, 33'h0);
        @(posedge clk);
        check(irq, 1'b0);
        apb(1'b1, 12'h010, 32'h2, 33'h0);
        apb(1'b1, 12'h00c, 32'h2, 33'h0);
        @(posedge clk);
        check(irq, 1'b0);
        irqMaskBits <= 8'h01;
        apb(1'b1, 12'h004, 32'hc0, 33'h0);
        apb(1'b0, 12'h004, 32'h0, 33'hc0);
        apb(1'b1, 12'h008, 32'h86, 33'h0);
        apb(1'b1, 12'h000, 32'h8, 33'h0);
        repeat (4) @(posedge clk);
        check({cpuHalt, fastOscEnable, clkSelInternal, slowOscLowPower,
               extOscEnable}, 5'h17);
        raiseIrq <= 8'h01;
        @(posedge clk);
        raiseIrq <= 8'h00;
        repeat (40) @(posedge clk);
        check(cpuHalt, 1'b1);
        raiseIrq <= 8'h02;
        @(posedge clk);
        raiseIrq <= 8'h00;
        waitWake();
        check(n >= 16, 1'b1);
        apb(1'b0, 12'h00c, 32'h0, 33'h4);
        clearIrq <= 8'h03;
        apb(1'b0, 12'h000, 32'h0, 33'h0);
        clearIrq <= 8'h00;
        apb(1'b1, 12'h000, 32'h9, 33'h0);
        raiseIrq <= 8'h02;
        @(posedge clk);
        raiseIrq <= 8'h00;
        repeat (40) @(posedge clk);
        check(cpuHalt, 1'b1);
        // code 11: eight slow ticks of eight cycles, seven of them gated
        n = 0;
        while (monitorSampleEn !== 1'b1 && n < 100) begin
            @(posedge clk);
            n++;
        end
        n = 0;
        while (monitorSampleEn !== 1'b0 && n < 100) begin
            @(posedge clk);
            n++;
        end
        n = 0;
        while (monitorSampleEn === 1'b0 && n < 100) begin
            @(posedge clk);
            n++;
        end
        check(n, 56);
        apb(1'b1, 12'h000, 32'h8, 33'h0);
        waitWake();
        check(cpuHalt, 1'b0);
        summarize();
    end
endmodule : sleep_wake_and_voltage_monitor_tb_top
